/* File: core/psp_defs.svh */
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH
`define PSP_CLK_HZ 40000000
`define PSP_NORMAL_PARK_MS 20
`define PSP_NORMAL_PARK_CYC ((`PSP_CLK_HZ / 1000) * `PSP_NORMAL_PARK_MS)
`define PSP_REG_OFF_MS 12
`define PSP_REG_OFF_CYC ((`PSP_CLK_HZ / 1000) * `PSP_REG_OFF_MS)
`define PSP_FAST_PARK_US 32
`define PSP_FAST_PARK_CYC ((`PSP_CLK_HZ / 1000000) * `PSP_FAST_PARK_US)
`define PSP_FILTER_NS 150
`define PSP_FILTER_CYC ((`PSP_CLK_HZ / 1000000) * `PSP_FILTER_NS / 1000 + 1)
`define PSP_GPIO_W 20
`define PSP_CNT_W 20
`endif

/* File: core/psp_park_filter.sv */
`include "psp_defs.svh"
`default_nettype none
module psp_park_filter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic raw_n,
  output logic clean_n
);
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic clean_reg;
  logic clean_next;

  always_comb
  begin
    sync_next = {sync_reg[0], raw_n};
    cnt_next = 4'h0;
    clean_next = clean_reg;
    // Level must persist longer than a slow edge may chatter
    if (sync_reg[1] != clean_reg)
    begin
      if (cnt_reg == 4'(`PSP_FILTER_CYC))
        clean_next = sync_reg[1];
      else
        cnt_next = cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync_reg <= 2'h3;
      cnt_reg <= 4'h0;
      clean_reg <= 1'b1;
    end
    else
    begin
      sync_reg <= sync_next;
      cnt_reg <= cnt_next;
      clean_reg <= clean_next;
    end
  end

  assign clean_n = clean_reg;

  AST_FILTER_BLOCKS_SHORT: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(clean_reg) |-> $past(sync_reg[1], 6) == clean_reg)
    else $error("Filter passed a short pulse");
endmodule : psp_park_filter
`default_nettype wire

/* File: core/psp_pkg.sv */
`default_nettype none
package psp_pkg;
  typedef enum logic [2:0] {
    PSP_ST_RESET = 3'b000,
    PSP_ST_PLL = 3'b001,
    PSP_ST_LOAD = 3'b010,
    PSP_ST_RUN = 3'b011,
    PSP_ST_NPARK = 3'b100,
    PSP_ST_FPARK = 3'b101,
    PSP_ST_REGOFF = 3'b110,
    PSP_ST_OFF = 3'b111
  } psp_state_t;
endpackage : psp_pkg
`default_nettype wire

/* File: core/psp_sequencer.sv */
`include "psp_defs.svh"
`default_nettype none
module psp_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic system_reset_n,
  input wire logic fast_park_warning_n,
  input wire logic projector_on_request,
  input wire logic pll_locked,
  input wire logic config_loaded,
  input wire logic park_done,
  output logic init_flag,
  output logic pll_start,
  output logic config_load_start,
  output logic normal_park_active,
  output logic fast_park_active,
  output logic reset_regulation_on,
  output logic light_source_pick_0,
  output logic light_source_pick_1,
  output logic mirror_array_reset_enable_n,
  output logic flash_io_oe,
  output logic [`PSP_GPIO_W-1:0] gpio_oe
);
  psp_pkg::psp_state_t state_reg;
  psp_pkg::psp_state_t state_next;
  logic [`PSP_CNT_W-1:0] cnt_reg;
  logic [`PSP_CNT_W-1:0] cnt_next;
  logic [1:0] rst_sync_reg;
  logic [1:0] on_sync_reg;
  logic [1:0] ack_sync_reg;
  logic [2:0] ack_next;
  logic [2:0] ack_reg;
  logic park_n;
  logic in_reset;
  logic init_reg;
  logic init_next;
  logic np_reg;
  logic np_next;
  logic fp_reg;
  logic fp_next;
  logic reg_on_reg;
  logic reg_on_next;
  logic oe_reg;
  logic oe_next;
  logic pll_reg;
  logic pll_next;
  logic load_reg;
  logic load_next;

  psp_park_filter u_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw_n(fast_park_warning_n),
    .clean_n(park_n)
  );

  // Status inputs come from other domains, so two stages each, except park_done which gets one
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rst_sync_reg <= 2'h0;
      on_sync_reg <= 2'h0;
      ack_sync_reg <= 2'h0;
      ack_reg <= 3'h0;
    end
    else
    begin
      rst_sync_reg <= {rst_sync_reg[0], system_reset_n};
      on_sync_reg <= {on_sync_reg[0], projector_on_request};
      ack_sync_reg <= {ack_sync_reg[0], pll_locked};
      ack_reg <= ack_next;
    end
  end

  always_comb
  begin
    ack_next = {ack_reg[1:0], config_loaded};
    ack_next[1] = park_done;
    ack_next[2] = ack_reg[0];
  end

  assign in_reset = ~rst_sync_reg[1];

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    init_next = init_reg;
    oe_next = 1'b1;
    reg_on_next = reg_on_reg;
    if (in_reset)
    begin
      // Reset pin overrides everything; outputs parked safe
      state_next = psp_pkg::PSP_ST_RESET;
      oe_next = 1'b0;
      init_next = 1'b0;
      reg_on_next = 1'b0;
      cnt_next = '0;
    end
    else
    begin
      case (state_reg)
        psp_pkg::PSP_ST_RESET:
        begin
          state_next = psp_pkg::PSP_ST_PLL;
          init_next = 1'b1;
        end
        psp_pkg::PSP_ST_PLL:
          if (ack_sync_reg[1])
            state_next = psp_pkg::PSP_ST_LOAD;
        psp_pkg::PSP_ST_LOAD:
          if (ack_reg[2])
          begin
            state_next = psp_pkg::PSP_ST_RUN;
            init_next = 1'b0;
            reg_on_next = 1'b1;
          end
        psp_pkg::PSP_ST_RUN:
          if (!on_sync_reg[1])
          begin
            state_next = psp_pkg::PSP_ST_NPARK;
            cnt_next = '0;
          end
        psp_pkg::PSP_ST_NPARK:
          // Deadline forces completion even without mirror ack
          if (ack_reg[1] || cnt_reg >= `PSP_CNT_W'(`PSP_NORMAL_PARK_CYC - 1))
          begin
            state_next = psp_pkg::PSP_ST_REGOFF;
            cnt_next = '0;
          end
          else
            cnt_next = cnt_reg + 1'b1;
        psp_pkg::PSP_ST_FPARK:
          if (cnt_reg >= `PSP_CNT_W'(`PSP_FAST_PARK_CYC - 1))
          begin
            state_next = psp_pkg::PSP_ST_OFF;
            reg_on_next = 1'b0;
          end
          else
            cnt_next = cnt_reg + 1'b1;
        psp_pkg::PSP_ST_REGOFF:
          if (cnt_reg >= `PSP_CNT_W'(`PSP_REG_OFF_CYC - 1))
          begin
            state_next = psp_pkg::PSP_ST_OFF;
            reg_on_next = 1'b0;
          end
          else
            cnt_next = cnt_reg + 1'b1;
        default:
          state_next = psp_pkg::PSP_ST_OFF;
      endcase
      // Fast park preempts any other activity, normal park included
      if (!park_n && state_reg != psp_pkg::PSP_ST_FPARK && state_reg != psp_pkg::PSP_ST_OFF)
      begin
        state_next = psp_pkg::PSP_ST_FPARK;
        cnt_next = '0;
        init_next = 1'b0;
      end
    end
    np_next = (state_next == psp_pkg::PSP_ST_NPARK);
    fp_next = (state_next == psp_pkg::PSP_ST_FPARK);
    pll_next = (state_next == psp_pkg::PSP_ST_PLL);
    load_next = (state_next == psp_pkg::PSP_ST_LOAD);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= psp_pkg::PSP_ST_RESET;
      cnt_reg <= '0;
      init_reg <= 1'b0;
      np_reg <= 1'b0;
      fp_reg <= 1'b0;
      reg_on_reg <= 1'b0;
      oe_reg <= 1'b0;
      pll_reg <= 1'b0;
      load_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      init_reg <= init_next;
      np_reg <= np_next;
      fp_reg <= fp_next;
      reg_on_reg <= reg_on_next;
      oe_reg <= oe_next;
      pll_reg <= pll_next;
      load_reg <= load_next;
    end
  end

  // Light picks are held low here; display logic owns them when running
  assign init_flag = init_reg;
  assign pll_start = pll_reg;
  assign config_load_start = load_reg;
  assign normal_park_active = np_reg;
  assign fast_park_active = fp_reg;
  assign reset_regulation_on = reg_on_reg;
  assign light_source_pick_0 = 1'b0;
  assign light_source_pick_1 = 1'b0;
  assign mirror_array_reset_enable_n = reg_on_reg;
  assign flash_io_oe = oe_reg;
  assign gpio_oe = {`PSP_GPIO_W{oe_reg}};

  sequence s_released;
    rst_sync_reg[1] && !$past(rst_sync_reg[1]);
  endsequence

  AST_TRISTATE_IN_RESET: assert property (@(posedge ref_clk) disable iff (rst)
    in_reset |=> !oe_reg)
    else $error("Outputs driven during reset");
  AST_SAFE_LOW_IN_RESET: assert property (@(posedge ref_clk) disable iff (rst)
    in_reset |=> !mirror_array_reset_enable_n)
    else $error("Mirror enable high in reset");
  AST_INIT_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    s_released ##0 park_n |=> init_reg)
    else $error("Init flag not raised");
  AST_ACTIVE_AFTER: assert property (@(posedge ref_clk) disable iff (rst)
    s_released |=> oe_reg)
    else $error("Outputs not active after release");
  AST_PLL_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
    load_reg && !$past(load_reg) |-> $past(pll_reg))
    else $error("Load before PLL");
  AST_INIT_DONE: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(init_reg) && !in_reset && park_n |-> state_reg == psp_pkg::PSP_ST_RUN)
    else $error("Init flag fell early");
  AST_NPARK_START: assert property (@(posedge ref_clk) disable iff (rst)
    state_reg == psp_pkg::PSP_ST_RUN && !on_sync_reg[1] && park_n && !in_reset |=> np_reg)
    else $error("Normal park not started");
  AST_NPARK_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
    np_reg |-> cnt_reg < `PSP_CNT_W'(`PSP_NORMAL_PARK_CYC))
    else $error("Normal park overran");
  AST_FAST_PARK: assert property (@(posedge ref_clk) disable iff (rst)
    !park_n && !in_reset && (np_reg || state_reg == psp_pkg::PSP_ST_RUN) |=> fp_reg)
    else $error("Fast park not started");
endmodule : psp_sequencer
`default_nettype wire

/* File: verification/power_sequence_park_control_tb_top.sv */
`include "psp_defs.svh"
`default_nettype none
module power_sequence_park_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic system_reset_n = 1'b0;
  logic fast_park_warning_n = 1'b1;
  logic projector_on_request = 1'b1;
  logic pll_locked, config_loaded, park_done, init_flag, pll_start, config_load_start;
  logic normal_park_active, fast_park_active, reset_regulation_on, light_source_pick_0;
  logic light_source_pick_1, mirror_array_reset_enable_n, flash_io_oe;
  logic [`PSP_GPIO_W-1:0] gpio_oe;
  int error_cnt = 0;
  int num_checks = 0;
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  psp_sequencer i_dut (.ref_clk, .rst, .system_reset_n, .fast_park_warning_n,
    .projector_on_request, .pll_locked, .config_loaded, .park_done, .init_flag,
    .pll_start, .config_load_start, .normal_park_active, .fast_park_active,
    .reset_regulation_on, .light_source_pick_0, .light_source_pick_1,
    .mirror_array_reset_enable_n, .flash_io_oe, .gpio_oe);
  psp_partner_model i_partner (.ref_clk, .rst, .pll_start, .config_load_start,
    .normal_park_active, .pll_locked, .config_loaded, .park_done);
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [`PSP_GPIO_W-1:0] exp,
    input logic [`PSP_GPIO_W-1:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  function automatic logic pick(input int s);
    case (s)
      0: return init_flag;
      1: return config_load_start;
      2: return normal_park_active;
      3: return fast_park_active;
      default: return park_done;
    endcase
  endfunction : pick
  // Bounded wait; running out ends the run
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v)
    begin
      @(negedge ref_clk);
      n++;
      if (n > lim)
      begin
        $display("ERROR wait %0d expected %b seen %b", s, v, pick(s));
        error_cnt++;
        end_of_test();
      end
    end
  endtask : wt
  task automatic t_boot();
    int n;
    @(posedge ref_clk);
    system_reset_n <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("flash_io_oe", 1'b0, flash_io_oe);
    chk("gpio_oe", '0, gpio_oe);
    chk("picks", 2'b00, {light_source_pick_1, light_source_pick_0});
    chk("mirror_en_n", 1'b0, mirror_array_reset_enable_n);
    @(posedge ref_clk);
    fast_park_warning_n <= 1'b1;
    projector_on_request <= 1'b1;
    // Supplies ideal from the start; long hold cut for run time
    repeat (12) @(posedge ref_clk);
    system_reset_n <= 1'b1;
    wt(0, 1'b1, 6, n);
    chk("gpio_oe", '1, gpio_oe);
    chk("flash_io_oe", 1'b1, flash_io_oe);
    chk("pll_start", 1'b1, pll_start);
    chk("cfg_start", 1'b0, config_load_start);
    wt(1, 1'b1, 40, n);
    chk("pll_start", 1'b0, pll_start);
    wt(0, 1'b0, 80, n);
    repeat (2) @(negedge ref_clk);
    chk("regulation", 1'b1, reset_regulation_on);
    chk("mirror_en_n", 1'b1, mirror_array_reset_enable_n);
    $display("test boot done");
  endtask : t_boot
  task automatic t_normal_park();
    int n;
    t_boot();
    @(posedge ref_clk);
    projector_on_request <= 1'b0;
    wt(2, 1'b1, 8, n);
    wt(4, 1'b1, 1000, n);
    wt(2, 1'b0, 10, n);
    repeat (1000) @(negedge ref_clk);
    // Full regulation hold is too long to run; only its start is seen
    chk("regulation", 1'b1, reset_regulation_on);
    chk("fast_park", 1'b0, fast_park_active);
    $display("test normal park done");
  endtask : t_normal_park
  task automatic t_fast_park();
    int n;
    t_boot();
    @(posedge ref_clk);
    fast_park_warning_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    fast_park_warning_n <= 1'b1;
    repeat (20) @(negedge ref_clk);
    chk("fast_park", 1'b0, fast_park_active);
    @(posedge ref_clk);
    fast_park_warning_n <= 1'b0;
    wt(3, 1'b1, 12, n);
    chk("filter_delay", 1'b1, n >= 6);
    wt(3, 1'b0, 1400, n);
    chk("fast_len", 1'b1, n >= 1200);
    chk("regulation", 1'b0, reset_regulation_on);
    $display("test fast park done");
  endtask : t_fast_park
  task automatic t_park_switch();
    int n;
    t_boot();
    @(posedge ref_clk);
    projector_on_request <= 1'b0;
    wt(2, 1'b1, 8, n);
    repeat (20) @(posedge ref_clk);
    fast_park_warning_n <= 1'b0;
    wt(3, 1'b1, 12, n);
    chk("normal_park", 1'b0, normal_park_active);
    $display("test park switch done");
  endtask : t_park_switch
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_normal_park();
    t_fast_park();
    t_park_switch();
    end_of_test();
  end
endmodule : power_sequence_park_control_tb_top
`default_nettype wire

/* File: verification/psp_partner_model.sv */
`default_nettype none
module psp_partner_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pll_start,
  input wire logic config_load_start,
  input wire logic normal_park_active,
  output logic pll_locked,
  output logic config_loaded,
  output logic park_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] req_reg;
  int cnt_reg;
  always_ff @(posedge ref_clk)
  begin
    req_reg <= {normal_park_active, config_load_start, pll_start};
    if (rst || req_reg != {normal_park_active, config_load_start, pll_start})
      cnt_reg <= 0;
    else
      cnt_reg <= cnt_reg + 1;
  end
  // Answers after the request has stood a while, or at once if the previous pattern stood that long, since the count clears a cycle late
  assign pll_locked = pll_start && cnt_reg >= 20;
  assign config_loaded = config_load_start && cnt_reg >= 40;
  assign park_done = normal_park_active && cnt_reg >= 300;
endmodule : psp_partner_model
`default_nettype wire
